/* File: rtl/mrrm_pkg.sv */
// Constants for the release, restart and mute wrapper
// Summary of operation
// - Monitoring error forces release low, flags error
// - Reset/restart needs low-high-low, debounce-long high
// - High phase over thirty seconds is rejected
// - Shortest debounce: no minimum width, one cycle
// - Debounce may demand 100 or 350 ms
// - Reset pending once error cause has cleared
// - Pending indication steady or flashing
// - Manual mode raises restart pending first
// - Valid restart while pending grants release
// - Restart after confirmation is ignored
// - Falling edge without rising edge rejected
// - Automatic mode releases without restart
// - Restart under bypass moves to regular run
// - Mute rise holds release, fall returns it
// - Mute holds only releases already active
// - Mute input is taken without debounce
// - Restart pending, mute, bypass, restart, errors optional
// - Time limit ends mute, at most 7200 s
// - Mute high at startup does not mute
// - Bypass rise grants release, fall returns it
package mrrm_pkg;
	// ==========================================
	// Timebase
	localparam int CLK_NS = 5;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int MS_W = 23;
	// ==========================================
	// Pulse and limit times in ms ticks, PULSE_MAX_S and TLIM_MAX_S in s
	localparam int DEB100_MS = 100;
	localparam int DEB350_MS = 350;
	localparam int PULSE_MAX_S = 30;
	localparam int PULSE_MAX_MS = PULSE_MAX_S * 1000;
	localparam int TLIM_MAX_S = 7200;
	localparam int TLIM_MAX_MS = TLIM_MAX_S * 1000;
	localparam int FLASH_MS = 500;
	localparam logic [MS_W-1:0] TLIM_RST = 23'h0003e8;
	// ==========================================
	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TLIM = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CTRL_W = 9;
	localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
	localparam int CB_MANUAL = 0;
	localparam int CB_DEB = 1;
	localparam int CB_FLASH = 3;
	localparam int CB_MUTE = 4;
	localparam int CB_BYP = 5;
	localparam int CB_RPEND = 6;
	localparam int CB_ERR = 7;
	localparam int CB_TLIM = 8;
	localparam logic [1:0] DEB_1 = 2'h0;
	localparam logic [1:0] DEB_100 = 2'h1;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// ==========================================
	// Release sequencing states
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_PEND = 2'b01,
		ST_RUN = 2'b10
	} mrrm_state_t;
endpackage : mrrm_pkg

/* File: rtl/mrrm_pulse.sv */
// Low-high-low pulse width checker
`timescale 1ns/1ps
module mrrm_pulse (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Timebase and least width
	input wire logic tick,
	input wire logic [mrrm_pkg::MS_W-1:0] min_ms,
	// Pulse level and verdicts
	mrrm_pulse_if.chk p
);
	import mrrm_pkg::*;
	logic prev_reg;
	logic armed_reg;
	logic [MS_W-1:0] wid_reg;
	logic ok_reg;
	logic bad_reg;
	wire rise = p.lvl & ~prev_reg;
	wire fall = ~p.lvl & prev_reg;
	wire over = wid_reg > MS_W'(PULSE_MAX_MS);
	wire grow = p.lvl & tick & ~over;
	wire wide = wid_reg >= min_ms;
	// too long a high phase fails
	wire good = armed_reg & wide & ~over;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prev_reg <= 1'b1;
			armed_reg <= 1'b0;
			wid_reg <= '0;
			ok_reg <= 1'b0;
			bad_reg <= 1'b0;
		end else begin
			prev_reg <= p.lvl;
			ok_reg <= fall & good;
			bad_reg <= fall & ~good;
			if (rise) begin
				armed_reg <= 1'b1;
				wid_reg <= '0;
			end else if (fall) begin
				armed_reg <= 1'b0;
			end else if (grow) begin
				wid_reg <= wid_reg + MS_W'(1);
			end
		end
	end
	assign p.ok = ok_reg;
	assign p.bad = bad_reg;
	property p_unarmed_bad;
		@(posedge sys_clk) disable iff (!nrst)
		fall && !armed_reg |=> bad_reg && !ok_reg;
	endproperty
	a_unarmed_bad: assert property (p_unarmed_bad)
		else $error("Unarmed fall not rejected");
	property p_long_bad;
		@(posedge sys_clk) disable iff (!nrst)
		fall && over |=> bad_reg;
	endproperty
	a_long_bad: assert property (p_long_bad)
		else $error("Overlong pulse accepted");
endmodule : mrrm_pulse

/* File: rtl/mrrm_pulse_if.sv */
// Operator pulse level and its verdicts
`timescale 1ns/1ps
interface mrrm_pulse_if;
	logic lvl;
	logic ok;
	logic bad;
	modport chk (input lvl, output ok, output bad);
	modport usr (output lvl, input ok, input bad);
endinterface : mrrm_pulse_if

/* File: rtl/mrrm_top.sv */
// Release, reset, restart and mute control
`timescale 1ns/1ps
module mrrm_top #(
	parameter int TICK_CYC = mrrm_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Operator and control inputs
	input wire logic reset_in,
	input wire logic restart_in,
	input wire logic mute_in,
	input wire logic bypass_in,
	// Evaluation side
	input wire logic eval_release,
	input wire logic mon_err,
	// Outputs
	output logic release_out,
	output logic error_out,
	output logic reset_pend_out,
	output logic restart_pend_out
);
	import mrrm_pkg::*;

	// ==========================================
	// Registers and state
	logic [CTRL_W-1:0] ctrl_reg;
	logic [MS_W-1:0] tlim_reg;
	logic [31:0] tick_cnt_reg;
	logic tick_reg;
	logic [MS_W-1:0] blink_cnt_reg;
	logic blink_reg;
	logic err_reg;
	logic err_next;
	mrrm_state_t st_reg;
	mrrm_state_t st_next;
	logic mute_prev_reg;
	logic byp_prev_reg;
	logic muted_reg;
	logic byp_reg;
	logic [MS_W-1:0] lim_cnt_reg;
	logic rel_reg;
	logic errf_reg;
	logic rspend_reg;
	logic rtpend_reg;

	// ==========================================
	// Configuration fields
	wire manual = ctrl_reg[CB_MANUAL];
	wire [1:0] deb_sel = ctrl_reg[CB_DEB +: 2];
	wire flash = ctrl_reg[CB_FLASH];
	wire use_mute = ctrl_reg[CB_MUTE];
	wire use_byp = ctrl_reg[CB_BYP];
	wire use_rpend = ctrl_reg[CB_RPEND];
	wire use_err = ctrl_reg[CB_ERR];
	wire lim_en = ctrl_reg[CB_TLIM];

	// ==========================================
	// Millisecond timebase and blinker
	wire tick_wrap = tick_cnt_reg == 32'(TICK_CYC - 1);
	wire blink_wrap = blink_cnt_reg == MS_W'(FLASH_MS - 1);
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			tick_cnt_reg <= 32'h0;
			tick_reg <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_wrap ? 32'h0 : tick_cnt_reg + 32'h1;
			tick_reg <= tick_wrap;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			blink_cnt_reg <= '0;
			blink_reg <= 1'b0;
		end else if (tick_reg) begin
			blink_cnt_reg <= blink_wrap ? '0 : blink_cnt_reg + MS_W'(1);
			blink_reg <= blink_reg ^ blink_wrap;
		end
	end

	// ==========================================
	// Pulse checkers
	mrrm_pulse_if rs_if ();
	mrrm_pulse_if rt_if ();
	wire [MS_W-1:0] min_ms = (deb_sel == DEB_1) ? '0
		: (deb_sel == DEB_100) ? MS_W'(DEB100_MS) : MS_W'(DEB350_MS);
	// Restart level unmasked, so a config write makes no false edge
	assign rs_if.lvl = reset_in;
	assign rt_if.lvl = restart_in;
	mrrm_pulse u_rs_chk (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.tick(tick_reg),
		.min_ms(min_ms),
		.p(rs_if.chk)
	);
	mrrm_pulse u_rt_chk (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.tick(tick_reg),
		.min_ms(min_ms),
		.p(rt_if.chk)
	);
	wire rs_ok = rs_if.ok;
	// restart verdict only in manual mode
	wire rt_ok = rt_if.ok & manual;

	// ==========================================
	// Error latch
	// set wins over the reset pulse
	assign err_next = mon_err | (err_reg & ~rs_ok);
	wire fault = err_reg | mon_err;

	// ==========================================
	// Mute and bypass edges
	// mute used as it arrives
	wire mute_on = use_mute & mute_in;
	wire byp_on = use_byp & bypass_in;
	wire mute_rise = mute_on & ~mute_prev_reg;
	wire mute_fall = ~mute_on & mute_prev_reg;
	wire byp_rise = byp_on & ~byp_prev_reg;
	wire byp_fall = ~byp_on & byp_prev_reg;
	wire expire = lim_en & (lim_cnt_reg >= tlim_reg);
	wire held = muted_reg | byp_reg;
	wire mute_set = mute_rise & rel_reg & ~fault;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mute_prev_reg <= 1'b1;
			byp_prev_reg <= 1'b1;
		end else begin
			mute_prev_reg <= mute_on;
			byp_prev_reg <= byp_on;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			muted_reg <= 1'b0;
		end else begin
			muted_reg <= mute_set | (muted_reg & ~mute_fall
				& ~expire & ~fault);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			byp_reg <= 1'b0;
		end else begin
			byp_reg <= (byp_rise & ~fault) | (byp_reg & ~byp_fall
				& ~expire & ~fault);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			lim_cnt_reg <= '0;
		end else if (!held) begin
			lim_cnt_reg <= '0;
		end else if (tick_reg && !expire) begin
			lim_cnt_reg <= lim_cnt_reg + MS_W'(1);
		end
	end

	// ==========================================
	// Release sequencing
	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			ST_OFF: begin
				if (!manual && eval_release) begin
					st_next = ST_RUN;
				end else if (manual && byp_reg && rt_ok) begin
					st_next = ST_RUN;
				end else if (manual && eval_release) begin
					st_next = ST_PEND;
				end
			end
			ST_PEND: begin
				if (rt_ok || !manual) begin
					st_next = ST_RUN;
				end else if (!eval_release && !byp_reg) begin
					st_next = ST_OFF;
				end
			end
			ST_RUN: begin
				if (!eval_release && !byp_reg) begin
					st_next = ST_OFF;
				end
			end
			default: begin
				st_next = ST_OFF;
			end
		endcase
		if (fault) begin
			st_next = ST_OFF;
		end
	end
	wire run_rel = (st_reg == ST_RUN) & (eval_release | byp_reg);
	wire rel_next = ~fault & (run_rel | held);
	wire rs_pend = err_reg & ~mon_err;
	wire rt_pend = use_rpend & manual & (st_reg == ST_PEND) & ~fault;
	wire show = ~flash | blink_reg;

	// ==========================================
	// Outputs, all from flip-flops
	// everything low after reset
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			err_reg <= 1'b0;
			st_reg <= ST_OFF;
			rel_reg <= 1'b0;
			errf_reg <= 1'b0;
			rspend_reg <= 1'b0;
			rtpend_reg <= 1'b0;
		end else begin
			err_reg <= err_next;
			st_reg <= st_next;
			rel_reg <= rel_next;
			errf_reg <= use_err & fault;
			// pending once the cause is gone
			rspend_reg <= rs_pend & show;
			rtpend_reg <= rt_pend & show;
		end
	end
	assign release_out = rel_reg;
	assign error_out = errf_reg;
	assign reset_pend_out = rspend_reg;
	assign restart_pend_out = rtpend_reg;

	// ==========================================
	// AXI4-Lite slave
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
	assign s_axi_arready = ~rvalid_reg;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire wr_go = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	wire wr_ctrl = wr_go & (awaddr_reg == REG_CTRL);
	wire wr_tlim = wr_go & (awaddr_reg == REG_TLIM);
	wire wr_map = (awaddr_reg == REG_CTRL) | (awaddr_reg == REG_TLIM)
		| (awaddr_reg == REG_STAT);
	wire [31:0] ctrl_word = {{(32-CTRL_W){1'b0}}, ctrl_reg};
	wire [31:0] tlim_word = {{(32-MS_W){1'b0}}, tlim_reg};
	wire [31:0] ctrl_mrg = (ctrl_word & ~wmask) | (wdata_reg & wmask);
	wire [31:0] tlim_mrg = (tlim_word & ~wmask) | (wdata_reg & wmask);
	wire [31:0] tlim_cap = (tlim_mrg > 32'(TLIM_MAX_MS))
		? 32'(TLIM_MAX_MS) : tlim_mrg;
	wire [31:0] stat_word = {24'h0, st_reg, byp_reg, muted_reg,
		rtpend_reg, rspend_reg, err_reg, rel_reg};
	wire rd_ctrl = s_axi_araddr == REG_CTRL;
	wire rd_tlim = s_axi_araddr == REG_TLIM;
	wire rd_stat = s_axi_araddr == REG_STAT;
	wire rd_map = rd_ctrl | rd_tlim | rd_stat;
	wire [31:0] rd_word = rd_ctrl ? ctrl_word : rd_tlim ? tlim_word
		: rd_stat ? stat_word : 32'h0;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_hold_reg <= 1'b0;
			end
			if (w_take) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end else if (wr_go) begin
				w_hold_reg <= 1'b0;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_reg <= CTRL_RST;
			tlim_reg <= TLIM_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= ctrl_mrg[CTRL_W-1:0];
			end
			if (wr_tlim) begin
				tlim_reg <= tlim_cap[MS_W-1:0];
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OK;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_map ? RESP_OK : RESP_ERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OK;
			rdata_reg <= 32'h0;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= rd_map ? RESP_OK : RESP_ERR;
			rdata_reg <= rd_word;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	// ==========================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_err_low;
		err_reg |=> !release_out;
	endproperty
	a_err_low: assert property (p_err_low)
		else $error("Release high during error");
	property p_err_flag;
		mon_err && use_err |=> error_out && err_reg;
	endproperty
	a_err_flag: assert property (p_err_flag)
		else $error("Error flag missing");
	property p_rs_pend;
		err_reg && !mon_err && !flash && !rs_ok |=> reset_pend_out;
	endproperty
	a_rs_pend: assert property (p_rs_pend)
		else $error("Reset pending not shown");
	property p_reset_clear;
		rs_ok && !mon_err |=> !err_reg;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("Valid reset ignored");
	property p_manual_wait;
		st_reg == ST_OFF && manual && eval_release && !fault
		&& !byp_reg && !held |=> st_reg == ST_PEND ##1 !release_out;
	endproperty
	a_manual_wait: assert property (p_manual_wait)
		else $error("Manual mode released without restart");
	sequence s_restart_taken;
		st_reg == ST_PEND && rt_ok && eval_release && !fault;
	endsequence
	property p_restart_run;
		s_restart_taken |=> st_reg == ST_RUN;
	endproperty
	a_restart_run: assert property (p_restart_run)
		else $error("Restart did not release");
	property p_auto_run;
		!manual && eval_release && !fault && !mon_err
		|=> st_reg == ST_RUN;
	endproperty
	a_auto_run: assert property (p_auto_run)
		else $error("Automatic release missing");
	sequence s_mute_live;
		mute_rise && rel_reg && !fault;
	endsequence
	property p_mute_hold;
		s_mute_live |=> muted_reg;
	endproperty
	a_mute_hold: assert property (p_mute_hold)
		else $error("Mute did not hold release");
	property p_mute_dead;
		mute_rise && !rel_reg |=> !muted_reg;
	endproperty
	a_mute_dead: assert property (p_mute_dead)
		else $error("Mute held an inactive release");
	property p_byp_on;
		byp_rise && !fault && !mon_err |=> ##1 release_out;
	endproperty
	a_byp_on: assert property (p_byp_on)
		else $error("Bypass did not release");
endmodule : mrrm_top

/* File: test/mrrm_partner.sv */
// Operator control and mute/bypass level model
`timescale 1ns/1ps
module mrrm_partner (
	// Clock
	input wire logic sys_clk,
	// Control levels
	output logic reset_in,
	output logic restart_in,
	output logic mute_in,
	output logic bypass_in
);
	// 0 reset, 1 restart, 2 mute, 3 bypass
	logic [3:0] lvl;
	assign reset_in = lvl[0];
	assign restart_in = lvl[1];
	assign mute_in = lvl[2];
	assign bypass_in = lvl[3];
	initial begin
		lvl = 4'h0;
	end
	// Bare level change, lets a fall come without a rise
	task set_lvl(input int s, input logic v);
		@(posedge sys_clk);
		lvl[s] <= v;
	endtask : set_lvl
	task pulse(input int s, input int cyc);
		set_lvl(s, 1'b1);
		repeat (cyc) @(posedge sys_clk);
		lvl[s] <= 1'b0;
	endtask : pulse
endmodule : mrrm_partner

/* File: test/test_motion_release_reset_restart_mute.sv */
// Self-checking bench for the release, restart and mute control
`timescale 1ns/1ps
module test_motion_release_reset_restart_mute;
	import mrrm_pkg::*;
	// ==========================================
	// Signals
	localparam int TK = 2;
	typedef struct packed {
		logic [8:0] ctrl;
		logic [4:0] io;
	} mrrm_tb_row_t;
	typedef struct packed {
		logic [1:0] deb;
		logic [15:0] tk;
		logic acc;
	} mrrm_tb_pulse_t;
	// io: eval, error cause, release, error flag, restart pending
	mrrm_tb_row_t rows [6] = '{{9'h000, 5'h14}, {9'h041, 5'h11},
		{9'h001, 5'h10}, {9'h000, 5'h00}, {9'h080, 5'h1a}, {9'h000, 5'h18}};
	mrrm_tb_pulse_t prow [6] = '{{2'h1, 16'h005a, 1'b0},
		{2'h1, 16'h006e, 1'b1}, {2'h2, 16'h0154, 1'b0},
		{2'h2, 16'h0168, 1'b1}, {2'h0, 16'h0002, 1'b1},
		{2'h0, 16'h753a, 1'b0}};
	logic sys_clk, nrst, eval_release, mon_err;
	logic reset_in, restart_in, mute_in, bypass_in;
	logic release_out, error_out, reset_pend_out, restart_pend_out;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	int errors, num_checks, hi;
	// ==========================================
	// Design and partner
	mrrm_top #(.TICK_CYC(TK)) u_mrrm_top (.sys_clk(sys_clk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .reset_in(reset_in),
		.restart_in(restart_in), .mute_in(mute_in), .bypass_in(bypass_in),
		.eval_release(eval_release), .mon_err(mon_err),
		.release_out(release_out), .error_out(error_out),
		.reset_pend_out(reset_pend_out),
		.restart_pend_out(restart_pend_out));
	mrrm_partner u_mrrm_partner (.sys_clk(sys_clk), .reset_in(reset_in),
		.restart_in(restart_in), .mute_in(mute_in), .bypass_in(bypass_in));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ==========================================
	// Tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d, errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	// Checks land on the falling edge, away from updates
	task wait_cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wait_cyc
	task set_in(input logic ev, input logic er);
		@(posedge sys_clk);
		eval_release <= ev;
		mon_err <= er;
	endtask : set_in
	task do_rst;
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
	endtask : do_rst
	task axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta, tw, done;
		done = 1'b0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(negedge sys_clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			done = bvalid;
			if (done) chk(32'(bresp), 32'(er));
			@(posedge sys_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask : axi_wr
	task axi_rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ta, done;
		done = 1'b0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(negedge sys_clk);
			ta = arvalid & arready;
			done = rvalid;
			if (done) chk(rdata, ed);
			if (done) chk(32'(rresp), 32'(er));
			@(posedge sys_clk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : axi_rd
	// ==========================================
	// Watchdog, about 90000 cycles
	initial begin
		#450000;
		errors++;
		end_sim();
	end
	// ==========================================
	// Main sequence
	initial begin
		{nrst, eval_release, mon_err, awvalid, wvalid, bready} = 6'h00;
		{arvalid, rready, awaddr, araddr, wdata} = 50'h0;
		wstrb = 4'hf;
		errors = 0;
		num_checks = 0;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		wait_cyc(1);
		chk(32'({release_out, error_out, reset_pend_out, restart_pend_out}),
			0);
		axi_rd(REG_CTRL, 32'(CTRL_RST), RESP_OK);
		axi_rd(REG_TLIM, 32'(TLIM_RST), RESP_OK);
		axi_rd(REG_STAT, 32'h0, RESP_OK);
		// Unmapped place refused both ways
		axi_wr(8'h0c, 32'h1, RESP_ERR);
		axi_rd(8'h0c, 32'h0, RESP_ERR);
		foreach (rows[i]) begin
			do_rst();
			axi_wr(REG_CTRL, 32'(rows[i].ctrl), RESP_OK);
			set_in(rows[i].io[4], rows[i].io[3]);
			wait_cyc(6);
			chk(32'({release_out, error_out, restart_pend_out}),
				32'(rows[i].io[2:0]));
			set_in(1'b0, 1'b0);
		end
		foreach (prow[i]) begin
			do_rst();
			axi_wr(REG_CTRL, 32'h80 | 32'(prow[i].deb) << 1, RESP_OK);
			set_in(1'b0, 1'b1);
			set_in(1'b0, 1'b0);
			wait_cyc(6);
			chk(32'(reset_pend_out), 1);
			u_mrrm_partner.pulse(0, TK * int'(prow[i].tk));
			wait_cyc(8);
			chk(32'(reset_pend_out), 32'(!prow[i].acc));
		end
		for (int f = 0; f < 2; f++) begin
			do_rst();
			axi_wr(REG_CTRL, 32'h80 | 32'(f) << CB_FLASH, RESP_OK);
			set_in(1'b0, 1'b1);
			set_in(1'b0, 1'b0);
			wait_cyc(6);
			hi = 0;
			repeat (2400) begin
				@(negedge sys_clk);
				if (reset_pend_out === 1'b1) hi++;
			end
			chk(32'(f ? (hi > 0 && hi < 2400) : hi == 2400), 1);
		end
		// Restart held across reset, then released
		u_mrrm_partner.set_lvl(1, 1'b1);
		do_rst();
		axi_wr(REG_CTRL, 32'h41, RESP_OK);
		set_in(1'b1, 1'b0);
		u_mrrm_partner.set_lvl(1, 1'b0);
		wait_cyc(8);
		chk(32'({release_out, restart_pend_out}), 32'h1);
		u_mrrm_partner.pulse(1, 3 * TK);
		wait_cyc(8);
		chk(32'({release_out, restart_pend_out}), 32'h2);
		u_mrrm_partner.pulse(1, 3 * TK);
		wait_cyc(8);
		axi_rd(REG_STAT, 32'h81, RESP_OK);
		// Mute already high at startup
		set_in(1'b0, 1'b0);
		u_mrrm_partner.set_lvl(2, 1'b1);
		do_rst();
		axi_wr(REG_CTRL, 32'h10, RESP_OK);
		set_in(1'b1, 1'b0);
		wait_cyc(5);
		set_in(1'b0, 1'b0);
		wait_cyc(5);
		chk(32'(release_out), 0);
		u_mrrm_partner.set_lvl(2, 1'b0);
		set_in(1'b1, 1'b0);
		wait_cyc(5);
		u_mrrm_partner.set_lvl(2, 1'b1);
		set_in(1'b0, 1'b0);
		wait_cyc(5);
		chk(32'(release_out), 1);
		u_mrrm_partner.set_lvl(2, 1'b0);
		wait_cyc(5);
		chk(32'(release_out), 0);
		u_mrrm_partner.set_lvl(2, 1'b1);
		set_in(1'b1, 1'b0);
		wait_cyc(5);
		set_in(1'b0, 1'b0);
		wait_cyc(5);
		chk(32'(release_out), 0);
		u_mrrm_partner.set_lvl(2, 1'b0);
		// Time limit clamp and expiry
		do_rst();
		axi_wr(REG_TLIM, 32'hffffffff, RESP_OK);
		axi_rd(REG_TLIM, 32'(TLIM_MAX_MS), RESP_OK);
		axi_wr(REG_TLIM, 32'h0000000a, RESP_OK);
		axi_wr(REG_CTRL, 32'h110, RESP_OK);
		set_in(1'b1, 1'b0);
		wait_cyc(5);
		u_mrrm_partner.set_lvl(2, 1'b1);
		set_in(1'b0, 1'b0);
		wait_cyc(4 * TK);
		chk(32'(release_out), 1);
		wait_cyc(16 * TK);
		chk(32'(release_out), 0);
		u_mrrm_partner.set_lvl(2, 1'b0);
		// Bypass, then restart under bypass
		do_rst();
		axi_wr(REG_CTRL, 32'h61, RESP_OK);
		u_mrrm_partner.set_lvl(3, 1'b1);
		wait_cyc(4);
		chk(32'(release_out), 1);
		u_mrrm_partner.set_lvl(3, 1'b0);
		wait_cyc(4);
		chk(32'(release_out), 0);
		u_mrrm_partner.set_lvl(3, 1'b1);
		u_mrrm_partner.pulse(1, 3 * TK);
		wait_cyc(8);
		set_in(1'b1, 1'b0);
		u_mrrm_partner.set_lvl(3, 1'b0);
		wait_cyc(6);
		chk(32'(release_out), 1);
		end_sim();
	end
endmodule : test_motion_release_reset_restart_mute
